// ==== sdwp_pkg.sv ====
// shared constants and types for the sdram write/power/precharge pair
package sdwp_pkg;
    localparam int DQ_W = 16;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int NBANK = 4;
    localparam int BANK_W = 2;
    localparam int AP_BIT = 10;
    localparam int CLK_NS = 100;
    // command codes on {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] BL_FULL = 3'h7;
    // timing
    localparam int TWR_EXTRA_NS = 10;
    localparam int TWR_CYC = 1 + (TWR_EXTRA_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRP_NS = 20;
    localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PD_MAX_MS = 64;
    localparam int PD_MAX_CYC = PD_MAX_MS * (1000000 / CLK_NS);
    localparam int PD_CNT_W = 20;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] TWR_CNT = CNT_W'(TWR_CYC);
    localparam logic [CNT_W-1:0] TRP_CNT = CNT_W'(TRP_CYC);
    localparam logic [CNT_W-1:0] RAP_CNT = 4'h1;
    localparam logic [CNT_W-1:0] RDG_CNT = 4'hC;
    localparam logic [1:0] GRD_PRE = 2'h1;
    localparam logic [1:0] GRD_WR = 2'h2;
    // controller registers
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_CFG = 8'h10;
    localparam int F_BANK = 4;
    localparam int F_ADDR = 6;
    localparam int F_DQM = 18;
    localparam int S_REFUSED = 2;
    localparam int S_PDTO = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {D_RUN = 2'h0, D_SUSP = 2'h1, D_PDA = 2'h3, D_PDP = 2'h2} sdwp_dstate_type;
    typedef enum logic [1:0] {C_IDLE = 2'h0, C_GUARD = 2'h1, C_PDOWN = 2'h3} sdwp_cstate_type;
endpackage

// ==== sdwp_if.sv ====
// memory pins between controller end and device end
`timescale 1ns/1ps
interface sdwp_if (input logic aclk);
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [sdwp_pkg::ADDR_W-1:0] addr;
    logic bank_select_low;
    logic bank_select_high;
    logic dqm;
    logic [sdwp_pkg::DQ_W-1:0] dq_ctrl_o;
    logic dq_ctrl_oe_n;
    logic [sdwp_pkg::DQ_W-1:0] dq_dev_o;
    logic dq_dev_oe_n;
    logic [sdwp_pkg::DQ_W-1:0] dq;
    // level on the shared data wire
    assign dq = !dq_ctrl_oe_n ? dq_ctrl_o : (!dq_dev_oe_n ? dq_dev_o : '0);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_low,
        bank_select_high, dqm, dq, output dq_dev_o, dq_dev_oe_n);
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_low,
        bank_select_high, dqm, dq_ctrl_o, dq_ctrl_oe_n, input dq, dq_dev_oe_n);
endinterface

// ==== sdwp_bank_track.sv ====
// per-bank open/idle state with pending auto precharge countdown
`timescale 1ns/1ps
module sdwp_bank_track (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    // bank events
    input wire logic act_valid,
    input wire logic [sdwp_pkg::BANK_W-1:0] act_bank,
    input wire logic pre_valid,
    input wire logic pre_all,
    input wire logic [sdwp_pkg::BANK_W-1:0] pre_bank,
    input wire logic arm_valid,
    input wire logic [sdwp_pkg::BANK_W-1:0] arm_bank,
    input wire logic [sdwp_pkg::CNT_W-1:0] arm_cnt,
    // state
    output logic [sdwp_pkg::NBANK-1:0] open_q
);
    import sdwp_pkg::*;
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        logic open_b_q;
        logic [CNT_W-1:0] cnt_q;
        wire hit_act = act_valid & (act_bank == BANK_W'(b));
        wire hit_pre = pre_valid & (pre_all | (pre_bank == BANK_W'(b)));
        wire hit_arm = arm_valid & (arm_bank == BANK_W'(b));
        assign open_q[b] = open_b_q;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                open_b_q <= 1'b0;
                cnt_q <= '0;
            end else if (en) begin
                if (hit_act) begin
                    open_b_q <= 1'b1;
                    cnt_q <= '0;
                end else if (hit_pre || (cnt_q == RAP_CNT)) begin
                    open_b_q <= 1'b0;
                    cnt_q <= '0;
                end else if (hit_arm) begin
                    cnt_q <= arm_cnt;
                end else if (cnt_q != '0) begin
                    cnt_q <= cnt_q - RAP_CNT;
                end
            end
        end
    end
endmodule

// ==== sdwp_device.sv ====
// sdram device end: bursts, truncation, suspend, precharge, power-down
`timescale 1ns/1ps
// What this block does
// - write data taken with command, then each edge
// - finished fixed write: pins idle, data ignored
// - full-page write runs on, column wraps to zero
// - new write truncates old, owns its data
// - read during write stops further writes
// - controller precharges two clocks after last data
// - write recovery is one clock plus extra
// - controller masks before and at precharge
// - no same-bank command before precharge period ends
// - burst terminate ends write, its data ignored
// - low clock enable suspends next internal edge
// - suspended edge: ignore inputs, hold outputs and burst counters; auto precharge countdown keeps running
// - high clock enable resumes on following edge
// - all-bank bit picks one or all banks
// - precharged bank idle until activated again
// - idle low clock enable with nop enters power-down
// - power-down kills buffers; leave within 64 ms
// - nop with clock enable high exits power-down
// - write burst mode bit forces single writes
// - other-bank access runs beside pending auto precharge
// - other-bank read cuts read with auto precharge
// - other-bank write cuts it; mask two clocks before
// - mask on write data has zero latency
module sdwp_device (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // mode settings
    input wire logic [2:0] burst_len_code,
    input wire logic cas_lat_three,
    input wire logic write_burst_mode_bit,
    // status
    output logic [sdwp_pkg::NBANK-1:0] bank_open_q,
    output logic suspended_q,
    output logic pd_precharge_q,
    output logic pd_active_q,
    // memory pins
    sdwp_if.dev mem
);
    import sdwp_pkg::*;
    localparam int MEM_D = NBANK << COL_W;
    localparam logic [COL_W-1:0] COL_ONE = 8'h01;

    logic [DQ_W-1:0] mem_q [MEM_D];
    sdwp_dstate_type state_q;
    sdwp_dstate_type state_d;
    logic acc_act_q;
    logic acc_wr_q;
    logic acc_full_q;
    logic acc_ap_q;
    logic [BANK_W-1:0] acc_bank_q;
    logic [COL_W-1:0] acc_col_q;
    logic [COL_W-1:0] acc_left_q;
    logic p0_vld_q;
    logic p1_vld_q;
    logic [DQ_W-1:0] p0_q;
    logic [DQ_W-1:0] p1_q;
    logic dm_q;
    logic [DQ_W-1:0] dq_o_q;
    logic dq_oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // command decode, only on internal edges that run
    wire run = (state_q == D_RUN);
    wire [2:0] cmd = {mem.ras_n, mem.cas_n, mem.we_n};
    wire sel = run & !mem.cs_n;
    wire nop_in = mem.cs_n | (cmd == CMD_NOP);
    wire do_act = sel & (cmd == CMD_ACT);
    wire do_rd = sel & (cmd == CMD_READ);
    wire do_wr = sel & (cmd == CMD_WRITE);
    wire do_pre = sel & (cmd == CMD_PRE);
    wire do_bst = sel & (cmd == CMD_BST);
    wire do_rw = do_rd | do_wr;
    wire pre_all = mem.addr[AP_BIT];
    wire [BANK_W-1:0] cmd_bank = {mem.bank_select_high, mem.bank_select_low};
    wire [COL_W-1:0] cmd_col = mem.addr[COL_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // burst sequencing
    wire cont = run & acc_act_q & !do_rw & !do_pre & !do_bst;
    wire end_burst = cont & !acc_full_q & (acc_left_q == '0);
    wire step = cont & !end_burst;
    wire [COL_W-1:0] step_col = acc_col_q + COL_ONE;
    wire [BANK_W-1:0] bank_now = do_rw ? cmd_bank : acc_bank_q;
    wire [COL_W-1:0] col_now = do_rw ? cmd_col : step_col;
    wire [BANK_W+COL_W-1:0] mem_idx = {bank_now, col_now};
    wire wr_now = (do_wr | (step & acc_wr_q)) & !mem.dqm;
    wire rd_now = do_rd | (step & !acc_wr_q);
    wire one_col = do_wr & write_burst_mode_bit;
    wire [COL_W-1:0] blen = COL_W'(1) << burst_len_code;
    wire [COL_W-1:0] left_new = one_col ? '0 : blen - COL_ONE;
    wire full_new = !one_col & (burst_len_code == BL_FULL);
    wire ap_arm = acc_act_q & acc_ap_q & (end_burst | do_rw);
    wire [CNT_W-1:0] arm_cnt = acc_wr_q ? TWR_CNT : RAP_CNT;

    ////////////////////////////////////////////////////////////////////////
    // output path and power state
    wire drv_vld = cas_lat_three ? p1_vld_q : p0_vld_q;
    wire [DQ_W-1:0] drv_dat = cas_lat_three ? p1_q : p0_q;
    wire busy = acc_act_q | p0_vld_q | p1_vld_q | !dq_oe_n_q;
    wire any_open = |bank_open_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            D_RUN: begin
                if (!mem.cke && busy) begin
                    state_d = D_SUSP;
                end else if (!mem.cke && nop_in) begin
                    state_d = any_open ? D_PDA : D_PDP;
                end
            end
            D_SUSP: begin
                if (mem.cke) begin
                    state_d = D_RUN;
                end
            end
            D_PDA, D_PDP: begin
                if (mem.cke && nop_in) begin
                    state_d = D_RUN;
                end
            end
            default: begin
                state_d = D_RUN;
            end
        endcase
    end

    sdwp_bank_track u_track (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(ce),
        .act_valid(do_act),
        .act_bank(cmd_bank),
        .pre_valid(do_pre),
        .pre_all(pre_all),
        .pre_bank(cmd_bank),
        .arm_valid(ap_arm),
        .arm_bank(acc_bank_q),
        .arm_cnt(arm_cnt),
        .open_q(bank_open_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // storage; data captured with the command and on each step
    always_ff @(posedge aclk) begin
        if (ce && wr_now) begin
            mem_q[mem_idx] <= mem.dq;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= D_RUN;
            suspended_q <= 1'b0;
            pd_precharge_q <= 1'b0;
            pd_active_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            suspended_q <= (state_d == D_SUSP);
            pd_precharge_q <= (state_d == D_PDP);
            pd_active_q <= (state_d == D_PDA);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_act_q <= 1'b0;
            acc_wr_q <= 1'b0;
            acc_full_q <= 1'b0;
            acc_ap_q <= 1'b0;
            acc_bank_q <= '0;
            acc_col_q <= '0;
            acc_left_q <= '0;
        end else if (ce && do_rw) begin
            acc_act_q <= 1'b1;
            acc_wr_q <= do_wr;
            acc_full_q <= full_new;
            acc_ap_q <= mem.addr[AP_BIT];
            acc_bank_q <= cmd_bank;
            acc_col_q <= cmd_col;
            acc_left_q <= left_new;
        end else if (ce && (do_pre || do_bst || end_burst)) begin
            acc_act_q <= 1'b0;
        end else if (ce && step) begin
            acc_col_q <= step_col;
            acc_left_q <= acc_full_q ? acc_left_q : acc_left_q - COL_ONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p0_vld_q <= 1'b0;
            p1_vld_q <= 1'b0;
            p0_q <= '0;
            p1_q <= '0;
            dm_q <= 1'b0;
        end else if (ce && run) begin
            p0_vld_q <= rd_now;
            p0_q <= mem_q[mem_idx];
            p1_vld_q <= p0_vld_q & !do_wr;
            p1_q <= p0_q;
            dm_q <= mem.dqm;
        end
    end

    // a write takes the pins off the bus at once; power-down kills the driver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_o_q <= '0;
            dq_oe_n_q <= 1'b1;
        end else if (ce && run) begin
            dq_o_q <= drv_dat;
            dq_oe_n_q <= !(drv_vld & !dm_q & !do_wr);
        end else if (ce && (state_q != D_SUSP)) begin
            dq_oe_n_q <= 1'b1;
        end
    end

    assign mem.dq_dev_o = dq_o_q;
    assign mem.dq_dev_oe_n = dq_oe_n_q;
endmodule

// ==== sdwp_ctrl.sv ====
// controller end: axi4-lite registers drive the memory pins one command at a time
`timescale 1ns/1ps
module sdwp_ctrl #(
    parameter int PD_LIMIT_CYC = sdwp_pkg::PD_MAX_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [sdwp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sdwp_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory pins
    sdwp_if.ctrl mem
);
    import sdwp_pkg::*;
    sdwp_cstate_type state_q;
    sdwp_cstate_type state_d;
    logic pend_q, dqmf_q, refused_q, rd_new_q, pd_req_q, pd_to_q;
    logic [2:0] code_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DQ_W-1:0] wdata_q, rdata_q;
    logic [NBANK-1:0] open_q;
    logic [CNT_W-1:0] trp_q, rdg_q;
    logic [1:0] grd_q;
    logic [PD_CNT_W-1:0] pd_cnt_q;
    logic issue;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_go = s_axi_awvalid & s_axi_wvalid & !s_axi_awready & !s_axi_bvalid;
    wire wr_hs = s_axi_awready;
    wire full_w = (s_axi_wstrb == 4'hF);
    wire hw_cmd = s_axi_awaddr == REG_CMD;
    wire hw_wd = s_axi_awaddr == REG_WDATA;
    wire hw_st = s_axi_awaddr == REG_STAT;
    wire hw_cfg = s_axi_awaddr == REG_CFG;
    wire w_ok = full_w & (hw_cmd | hw_wd | hw_st | hw_cfg);
    wire w_take = wr_hs & w_ok;
    wire rd_go = s_axi_arvalid & !s_axi_arready & !s_axi_rvalid;
    wire rd_hs = s_axi_arready;
    wire [31:0] stat_word = {20'h0, open_q, 3'h0, pd_to_q, rd_new_q, refused_q,
        state_q == C_PDOWN, pend_q};
    wire hr_st = s_axi_araddr == REG_STAT;
    wire hr_rd = s_axi_araddr == REG_RDATA;
    wire hr_cfg = s_axi_araddr == REG_CFG;
    wire r_ok = hr_st | hr_rd | hr_cfg;
    wire [31:0] r_word = hr_st ? stat_word : (hr_rd ? {16'h0, rdata_q} : {31'h0, pd_req_q});

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    wire is_pre = code_q == CMD_PRE;
    wire is_wr = code_q == CMD_WRITE;
    wire is_rw = is_wr | (code_q == CMD_READ);
    wire closed = is_rw & !open_q[bank_q];
    wire can_go = pend_q & (trp_q == '0) & !closed;
    wire pd_full = pd_cnt_q == PD_CNT_W'(PD_LIMIT_CYC - 1);
    wire pd_end = !pd_req_q | pd_full;
    wire ap_bit = addr_q[AP_BIT];

    always_comb begin
        state_d = state_q;
        issue = 1'b0;
        case (state_q)
            C_IDLE: begin
                if (pd_req_q && !pd_to_q && !pend_q) begin
                    state_d = C_PDOWN;
                end else if (can_go && (is_pre || (is_wr && rdg_q != '0))) begin
                    state_d = C_GUARD;
                end else if (can_go) begin
                    issue = 1'b1;
                end
            end
            C_GUARD: begin
                if (grd_q == GRD_PRE) begin
                    issue = 1'b1;
                    state_d = C_IDLE;
                end
            end
            C_PDOWN: begin
                if (pd_end) begin
                    state_d = C_IDLE;
                end
            end
            default: begin
                state_d = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= C_IDLE;
            grd_q <= '0;
            trp_q <= '0;
            rdg_q <= '0;
            pd_cnt_q <= '0;
            open_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            grd_q <= (state_q == C_IDLE) ? (is_pre ? GRD_PRE : GRD_WR) : grd_q - 2'h1;
            trp_q <= (issue && is_pre) ? TRP_CNT : (trp_q != '0 ? trp_q - 4'h1 : trp_q);
            rdg_q <= (issue && code_q == CMD_READ) ? RDG_CNT : (rdg_q != '0 ? rdg_q - 4'h1 : rdg_q);
            pd_cnt_q <= (state_q == C_PDOWN) ? pd_cnt_q + 20'h1 : '0;
            if (issue && code_q == CMD_ACT) begin
                open_q[bank_q] <= 1'b1;
            end else if (issue && is_pre && ap_bit) begin
                open_q <= '0;
            end else if (issue && (is_pre || (is_rw && ap_bit))) begin
                open_q[bank_q] <= 1'b0;
            end
        end
    end

    // pins come straight from flops, one command per issue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem.cke <= 1'b1;
            mem.cs_n <= 1'b1;
            {mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP;
            mem.addr <= '0;
            {mem.bank_select_high, mem.bank_select_low} <= '0;
            mem.dqm <= 1'b1;
            mem.dq_ctrl_o <= '0;
            mem.dq_ctrl_oe_n <= 1'b1;
        end else if (ce) begin
            mem.cke <= (state_d != C_PDOWN);
            mem.cs_n <= 1'b0;
            {mem.ras_n, mem.cas_n, mem.we_n} <= issue ? code_q : CMD_NOP;
            mem.addr <= addr_q;
            {mem.bank_select_high, mem.bank_select_low} <= bank_q;
            mem.dqm <= issue ? (is_pre | dqmf_q) : (state_d == C_GUARD);
            mem.dq_ctrl_o <= wdata_q;
            mem.dq_ctrl_oe_n <= !(issue & is_wr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers and axi answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            code_q <= CMD_NOP;
            bank_q <= '0;
            addr_q <= '0;
            dqmf_q <= 1'b0;
            wdata_q <= '0;
            pd_req_q <= 1'b0;
        end else if (ce) begin
            if (w_take && hw_cmd && !pend_q) begin
                pend_q <= 1'b1;
                code_q <= s_axi_wdata[2:0];
                bank_q <= s_axi_wdata[F_BANK +: BANK_W];
                addr_q <= s_axi_wdata[F_ADDR +: ADDR_W];
                dqmf_q <= s_axi_wdata[F_DQM];
            end else if (issue || (state_q == C_IDLE && pend_q && closed)) begin
                pend_q <= 1'b0;
            end
            if (w_take && hw_wd) begin
                wdata_q <= s_axi_wdata[DQ_W-1:0];
            end
            if (w_take && hw_cfg) begin
                pd_req_q <= s_axi_wdata[0];
            end
        end
    end

    // sticky flags: a hardware set wins over a software clear
    wire set_ref = (w_take & hw_cmd & pend_q) | (state_q == C_IDLE & pend_q & closed);
    wire clr_st = w_take & hw_st;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_q <= 1'b0;
            pd_to_q <= 1'b0;
            rd_new_q <= 1'b0;
            rdata_q <= '0;
        end else if (ce) begin
            refused_q <= set_ref | (refused_q & !(clr_st & s_axi_wdata[S_REFUSED]));
            pd_to_q <= (state_q == C_PDOWN & pd_full) | (pd_to_q & !(clr_st & s_axi_wdata[S_PDTO]));
            rd_new_q <= !mem.dq_dev_oe_n | (rd_new_q & !(rd_hs & hr_rd));
            if (!mem.dq_dev_oe_n) begin
                rdata_q <= mem.dq;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else if (ce) begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_hs) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= rd_go;
            if (rd_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata <= r_ok ? r_word : '0;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== sdwp_sva.sv ====
// checks on the memory pins between the two ends
`timescale 1ns/1ps
module sdwp_sva (
    // clock, reset and memory pins
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic dqm,
    input wire logic dq_ctrl_oe_n,
    input wire logic dq_dev_oe_n
);
    import sdwp_pkg::*;
    wire logic wr = !cs_n && {ras_n, cas_n, we_n} == CMD_WRITE;
    wire logic pre = !cs_n && {ras_n, cas_n, we_n} == CMD_PRE;
    wire logic nop = !cs_n && {ras_n, cas_n, we_n} == CMD_NOP;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_ONE_DRV: assert property (dq_ctrl_oe_n || dq_dev_oe_n) else $error("dq clash");
    AST_WR_DATA: assert property (wr |-> !dq_ctrl_oe_n) else $error("no write data");
    AST_WR_DROP: assert property (wr |=> dq_ctrl_oe_n) else $error("data held");
    AST_PRE_DQM: assert property (pre |-> dqm && $past(dqm)) else $error("unmasked");
    AST_PRE_GAP: assert property (pre |-> $past(nop)) else $error("no gap");
    AST_TRP: assert property (pre |=> nop) else $error("early command");
    AST_PD_NOP: assert property (!cke |-> nop) else $error("command in power-down");
    AST_PD_EXIT: assert property ($rose(cke) |-> nop) else $error("bad exit");
    COV_WR: cover property (wr);
    COV_PRE: cover property (pre);
    COV_PD: cover property ($fell(cke) ##[1:60] $rose(cke));
endmodule

// ==== sdwp_tb_top.sv ====
// bench joining the controller and device ends
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sdwp_tb_top;
    import sdwp_pkg::*;
    logic aclk = 0, aresetn = 0, run = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [1:0] rs;
    logic [29:0] r;
    logic [2:0] bl = 3'h0;
    wire awready, wready, bvalid, arready, rvalid, pa, pp, su;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] bo;
    int n_errors = 0, compares = 0;
    // rows: open banks after, bank, column, data
    logic [29:0] rows [3] = '{{4'h1, 2'h0, 8'h00, 16'h1234}, {4'h3, 2'h1, 8'hFF, 16'hA5C3},
        {4'hB, 2'h3, 8'h5A, 16'h0001}};
    always #50 aclk = ~aclk;
    sdwp_if sdwp_if_i (.aclk(aclk));
    sdwp_ctrl #(.PD_LIMIT_CYC(50)) sdwp_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(run),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem(sdwp_if_i.ctrl));
    sdwp_device sdwp_device_i (.aclk(aclk), .aresetn(aresetn), .ce(run), .burst_len_code(bl),
        .cas_lat_three(1'b0), .write_burst_mode_bit(1'b1), .bank_open_q(bo), .suspended_q(su),
        .pd_precharge_q(pp), .pd_active_q(pa), .mem(sdwp_if_i.dev));
    sdwp_sva sdwp_sva_i (.aclk(aclk), .aresetn(aresetn), .cke(sdwp_if_i.cke),
        .cs_n(sdwp_if_i.cs_n), .ras_n(sdwp_if_i.ras_n), .cas_n(sdwp_if_i.cas_n),
        .we_n(sdwp_if_i.we_n), .dqm(sdwp_if_i.dqm), .dq_ctrl_oe_n(sdwp_if_i.dq_ctrl_oe_n),
        .dq_dev_oe_n(sdwp_if_i.dq_dev_oe_n));
    task automatic final_report();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(inout int n);
        @(posedge aclk);
        if (++n > 99) begin
            n_errors++;
            final_report();
        end
    endtask
    // one axi4-lite write (w=1) or read (w=0)
    task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        do tick(n); while (w ? !(awready && wready) : !arready);
        {awvalid, wvalid, arvalid} <= 3'h0;
        while (w ? !bvalid : !rvalid) tick(n);
        rd = rdata;
        rs = w ? bresp : rresp;
        {bready, rready} <= 2'h0;
        @(posedge aclk);
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do ax(0, REG_STAT, 32'h0); while (rd[b] !== v && ++k < 30);
        `CHK(rd[b], v)
    endtask
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
        ax(1, REG_CMD, {14'h0, a, b, 1'h0, c});
        poll(0, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        ax(0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0)
        foreach (rows[i]) begin
            r = rows[i];
            cmd(CMD_ACT, r[25:24], 12'h0);
            ax(1, REG_WDATA, {16'h0, r[15:0]});
            cmd(CMD_WRITE, r[25:24], {4'h0, r[23:16]});
            cmd(CMD_READ, r[25:24], {4'h0, r[23:16]});
            poll(3, 1'b1);
            `CHK(rd[11:8], r[29:26])
            ax(0, REG_RDATA, 32'h0);
            `CHK(rd[15:0], r[15:0])
            `CHK(bo, r[29:26])
            $display("row %0d done", i);
        end
        // full-page read keeps the device busy, so low clock enable suspends it
        bl <= BL_FULL;
        cmd(CMD_READ, 2'h3, 12'h0);
        ax(1, REG_CFG, 32'h1);
        poll(1, 1'b1);
        `CHK(su, 1'b1)
        ax(1, REG_CFG, 32'h0);
        poll(1, 1'b0);
        `CHK(su, 1'b0)
        cmd(CMD_BST, 2'h3, 12'h0);
        bl <= 3'h0;
        `CHK(sdwp_if_i.dq_dev_oe_n, 1'b1)
        $display("suspend test done");
        ax(1, REG_CFG, 32'h1);
        poll(1, 1'b1);
        `CHK(pa, 1'b1)
        ax(1, REG_CFG, 32'h0);
        poll(1, 1'b0);
        cmd(CMD_PRE, 2'h1, 12'h0);
        `CHK(bo, 4'h9)
        cmd(CMD_PRE, 2'h2, 12'h400);
        `CHK(bo, 4'h0)
        cmd(CMD_WRITE, 2'h0, 12'h0);
        poll(2, 1'b1);
        ax(1, REG_CFG, 32'h1);
        poll(1, 1'b1);
        `CHK(pp, 1'b1)
        poll(4, 1'b1);
        `CHK(pp, 1'b0)
        ax(0, 8'hFC, 32'h0);
        `CHK(rs, RESP_SLVERR)
        $display("hand tests done");
        // mid-run reset clears sticky flags and bank view
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        ax(0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0)
        $display("reset test done");
        final_report();
    end
endmodule
